// *** pkg/pgd_pkg.sv ***
// constants and types for the power-good and driver mode logic
package pgd_pkg;

    localparam int CLK_HZ       = 25_000_000;
    localparam int PG_DELAY_US  = 5000;
    localparam int HOLD_US      = 20;
    localparam int PG_DELAY_CYC = (CLK_HZ / 1_000_000) * PG_DELAY_US;
    localparam int HOLD_CYC     = (CLK_HZ / 1_000_000) * HOLD_US;
    localparam int HOLD_W       = $clog2(HOLD_CYC + 1);

    localparam int AW = 4;
    localparam int DW = 32;

    localparam logic [AW-1:0] ADDR_CTRL     = 4'h0;
    localparam logic [AW-1:0] ADDR_STATUS   = 4'h4;
    localparam logic [AW-1:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [AW-1:0] ADDR_IRQ_MASK = 4'hC;

    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_W       = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 1'h1;

    localparam int IRQ_PG_RISE  = 0;
    localparam int IRQ_PG_FALL  = 1;
    localparam int IRQ_RAILS    = 2;
    localparam int IRQ_OFF_DONE = 3;
    localparam int IRQ_W        = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    localparam int SYNC_EN    = 0;
    localparam int SYNC_RAILS = 1;
    localparam int SYNC_PHASE3_CURRENT_SENSE_POS  = 2;
    localparam int SYNC_UPPER = 3;
    localparam int SYNC_LOWER = 4;
    localparam int SYNC_W     = 5;

    typedef enum logic [2:0] {
        ST_OFF    = 3'h0,
        ST_SSTART = 3'h1,
        ST_BOOT   = 3'h2,
        ST_DELAY  = 3'h3,
        ST_RUN    = 3'h4,
        ST_SSTOP  = 3'h5
    } pgd_state_e;

    typedef struct packed {
        logic above_upper;
        logic below_lower;
    } pgd_fb_s;

    typedef struct packed {
        logic slew_active;
        logic slew_down;
        logic skip_mode;
        logic sstart_done;
        logic sstop_done;
        logic all_phases;
    } pgd_reg_s;

endpackage : pgd_pkg

// *** hw/pgd_top.sv ***
// power-good, clock-enable, driver-skip and phase gating logic
//
// Function
// RQ1: after a transition and outside power-up or power-down, power-ok is released while feedback is in regulation.
// RQ2: power-ok is held low during startup and while the output sits at boot voltage.
// RQ3: power-ok stays low 5 ms after clock-enable falls, then follows the feedback window.
// RQ4: power-ok is forced low during soft-shutdown and in shutdown.
// RQ5: power-ok is released while slewing and for 20 us after the slew ends.
// RQ6: on a downward slew in skip mode the upper threshold is ignored until the hold ends and feedback is in regulation;
// the code ends it at hold end once feedback is not below the lower threshold.
// RQ7: driver-skip is driven high to ask the external drivers for forced-PWM.
// RQ8: with driver-skip low the external drivers run pulse-skipping.
// RQ9: driver-skip goes low when soft-shutdown completes, telling the drivers to shut down.
// RQ10: the phase-3 PWM output is three-stated when off, when its sense input is at bias, or with fewer phases.
// RQ11: the phase-2 boost switch is closed only while the phase-2 low gate is high.
// RQ12: clock-enable is forced high in shutdown and soft-start or soft-stop, otherwise it is the inverse of power-ok apart from the delay.
// RQ13: clock-enable is forced low while slewing and for 20 us after.
// RQ14: when system rails fail in operation clock-enable goes high, power-ok low, and a quarter-rate skip slew to boot is requested.
// RQ15: the 5 ms and 20 us intervals come from counters that restart on each new trigger.
`timescale 1ns/1ns

module pgd_top
    import pgd_pkg::*;
#(
    parameter int PG_DELAY_CYCLES = PG_DELAY_CYC
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    input  wire logic [AW-1:0] bus_addr,
    input  wire logic [DW-1:0] bus_wdata,
    input  wire logic          bus_wr,
    input  wire logic          bus_rd,
    output logic      [DW-1:0] bus_rdata,
    output logic               irq_out,
    input  wire logic          enable_pin,
    input  wire logic          system_rails_good_in,
    input  wire logic          phase3_current_sense_pos,
    input  wire pgd_fb_s       feedback_sense,
    input  wire pgd_reg_s      reg_status,
    input  wire logic          phase3_pwm_in,
    input  wire logic          phase2_low_gate,
    output logic               power_ok_out,
    output logic               power_ok_oe,
    output logic               clock_enable_n_out,
    output logic               clock_enable_n_oe,
    output logic               driver_skip_ctl_out,
    output logic               phase3_pwm_out,
    output logic               phase3_pwm_oe,
    output logic               phase2_boost_sw_on,
    output logic               boot_quarter_slew_out
);

    localparam int DLY_W = $clog2(PG_DELAY_CYCLES + 1);
    localparam logic [DLY_W-1:0] DLY_LOAD = DLY_W'(PG_DELAY_CYCLES);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);

    if (PG_DELAY_CYCLES < 2) begin : g_chk
        $error("PG_DELAY_CYCLES must be at least 2");
    end

    // the hold and register fields are fixed by the package
    if (HOLD_CYC < 1) begin : g_chk_hold
        $error("HOLD_CYC must be at least 1");
    end

    if (IRQ_W > DW || CTRL_W > DW) begin : g_chk_bus
        $error("register fields wider than the data bus");
    end

    // pin inputs: two-flop synchronisers
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;

    assign pin_raw[SYNC_EN]    = enable_pin;
    assign pin_raw[SYNC_RAILS] = system_rails_good_in;
    assign pin_raw[SYNC_PHASE3_CURRENT_SENSE_POS]  = phase3_current_sense_pos;
    assign pin_raw[SYNC_UPPER] = feedback_sense.above_upper;
    assign pin_raw[SYNC_LOWER] = feedback_sense.below_lower;

    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                sync1_reg[i] <= 1'b0;
                sync2_reg[i] <= 1'b0;
            end else if (clk_en) begin
                sync1_reg[i] <= pin_raw[i];
                sync2_reg[i] <= sync1_reg[i];
            end
        end
    end

    wire en_pin     = sync2_reg[SYNC_EN];
    wire rails_good = sync2_reg[SYNC_RAILS];
    wire phase3_current_sense_pos_bias  = sync2_reg[SYNC_PHASE3_CURRENT_SENSE_POS];
    wire fb_upper   = sync2_reg[SYNC_UPPER];
    wire fb_lower   = sync2_reg[SYNC_LOWER];

    // registers
    logic [CTRL_W-1:0] ctrl_reg;
    logic [IRQ_W-1:0]  irq_stat_reg;
    logic [IRQ_W-1:0]  irq_stat_next;
    logic [IRQ_W-1:0]  irq_mask_reg;
    logic [DW-1:0]     rdata_next;

    pgd_state_e        state_reg;
    pgd_state_e        state_next;
    logic [DLY_W-1:0]  dly_reg;
    logic [DLY_W-1:0]  dly_next;
    logic [HOLD_W-1:0] hold_reg;
    logic [HOLD_W-1:0] hold_next;
    logic              blank_reg;
    logic              blank_next;
    logic              quarter_reg;
    logic              quarter_next;

    wire sw_en = ctrl_reg[CTRL_EN_BIT];
    wire run_en = sw_en & en_pin;
    wire slewing = reg_status.slew_active;

    // states in which both open-drain pins sit at their idle side
    function automatic logic held_idle(input pgd_state_e s);
        return (s == ST_OFF) | (s == ST_SSTART) | (s == ST_SSTOP)
             | (s == ST_BOOT);
    endfunction : held_idle

    // sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (run_en)
                    state_next = ST_SSTART;
            end
            ST_SSTART: begin
                if (!run_en)
                    state_next = ST_SSTOP;
                else if (reg_status.sstart_done)
                    state_next = ST_BOOT;
            end
            ST_BOOT: begin
                if (!run_en)
                    state_next = ST_SSTOP;
                else if (rails_good)
                    state_next = ST_DELAY;
            end
            ST_DELAY: begin
                if (!run_en)
                    state_next = ST_SSTOP;
                else if (!rails_good)
                    state_next = ST_BOOT;
                else if (dly_reg == DLY_W'(1))
                    state_next = ST_RUN; // RQ3
            end
            ST_RUN: begin
                if (!run_en)
                    state_next = ST_SSTOP;
                else if (!rails_good)
                    state_next = ST_BOOT; // RQ14
            end
            ST_SSTOP: begin
                if (reg_status.sstop_done)
                    state_next = ST_OFF;
            end
            default: state_next = ST_OFF;
        endcase
    end

    // delay counter reloads on every entry to the delay state
    assign dly_next = (state_reg != ST_DELAY) ? DLY_LOAD
                    : dly_reg - DLY_W'(1); // RQ15

    // hold restarts while the slew controller runs
    wire hold_busy = slewing | (hold_reg != '0);
    assign hold_next = slewing ? HOLD_LOAD // RQ15
                     : (hold_reg != '0) ? hold_reg - HOLD_W'(1)
                     : hold_reg;

    // upper-threshold blanking for downward skip-mode slews
    wire blank_start = slewing & reg_status.slew_down
                     & reg_status.skip_mode;
    assign blank_next = blank_start
                      | (blank_reg & (hold_busy | fb_lower)); // RQ6

    // quarter-rate return to boot after a rails failure
    wire rails_lost = (state_reg == ST_RUN) & run_en & ~rails_good;
    assign quarter_next = rails_lost
                        | (quarter_reg & (state_next == ST_BOOT)); // RQ14

    wire in_window = ~fb_lower & (~fb_upper | blank_reg); // RQ6

    // rails loss pulls power-ok low before the state has moved
    wire pg_low = held_idle(state_reg) | (state_reg == ST_DELAY)
                | rails_lost; // RQ2 RQ4
    wire pg_next = ~pg_low & (hold_busy | in_window); // RQ1 RQ5

    // clock-enable is active low; the delay state keeps it asserted
    wire ck_high = held_idle(state_reg) | rails_lost; // RQ12
    wire ck_low = hold_busy | (state_reg == ST_DELAY); // RQ13
    wire ckn_next = ck_high ? 1'b1 : ck_low ? 1'b0 : ~pg_next; // RQ12

    // forced-PWM unless skip is asked or the supply is off
    wire skip_req = reg_status.skip_mode | quarter_next;
    wire driver_skip_ctl_out_next = (state_next != ST_OFF) & ~skip_req; // RQ7 RQ9

    wire p3_on = (state_reg != ST_OFF) & ~phase3_current_sense_pos_bias
               & reg_status.all_phases; // RQ10

    // interrupt events
    logic [IRQ_W-1:0] irq_ev;
    assign irq_ev[IRQ_PG_RISE]  = pg_next & ~power_ok_out;
    assign irq_ev[IRQ_PG_FALL]  = ~pg_next & power_ok_out;
    assign irq_ev[IRQ_RAILS]    = rails_lost;
    assign irq_ev[IRQ_OFF_DONE] = (state_reg == ST_SSTOP)
                                & (state_next == ST_OFF);

    // register access
    wire wr_ctrl = bus_wr & (bus_addr == ADDR_CTRL);
    wire wr_mask = bus_wr & (bus_addr == ADDR_IRQ_MASK);
    wire rd_stat = bus_rd & (bus_addr == ADDR_IRQ_STAT);

    // a new event wins over the read that clears
    assign irq_stat_next = (rd_stat ? '0 : irq_stat_reg) | irq_ev;

    wire [DW-1:0] status_word = {
        24'h0000_00, blank_reg, quarter_reg,
        clock_enable_n_out, power_ok_out, 1'b0, state_reg
    };

    always_comb begin
        rdata_next = '0;
        if (bus_rd) begin
            case (bus_addr)
                ADDR_CTRL:     rdata_next = DW'(ctrl_reg);
                ADDR_STATUS:   rdata_next = status_word;
                ADDR_IRQ_STAT: rdata_next = DW'(irq_stat_reg);
                ADDR_IRQ_MASK: rdata_next = DW'(irq_mask_reg);
                default:       rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_reg     <= CTRL_RST;
            irq_mask_reg <= IRQ_MASK_RST;
            irq_stat_reg <= '0;
            bus_rdata    <= '0;
            irq_out      <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl)
                ctrl_reg <= bus_wdata[CTRL_W-1:0];
            if (wr_mask)
                irq_mask_reg <= bus_wdata[IRQ_W-1:0];
            irq_stat_reg <= irq_stat_next;
            bus_rdata    <= rdata_next;
            irq_out      <= |(irq_stat_next & irq_mask_reg);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg   <= ST_OFF;
            dly_reg     <= DLY_LOAD;
            hold_reg    <= '0;
            blank_reg   <= 1'b0;
            quarter_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg   <= state_next;
            dly_reg     <= dly_next;
            hold_reg    <= hold_next;
            blank_reg   <= blank_next;
            quarter_reg <= quarter_next;
        end
    end

    // pins: oe high means the pin is pulled low or driven
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            power_ok_out          <= 1'b0;
            power_ok_oe           <= 1'b1;
            clock_enable_n_out    <= 1'b1;
            clock_enable_n_oe     <= 1'b0;
            driver_skip_ctl_out   <= 1'b0;
            phase3_pwm_out        <= 1'b0;
            phase3_pwm_oe         <= 1'b0;
            phase2_boost_sw_on    <= 1'b0;
            boot_quarter_slew_out <= 1'b0;
        end else if (clk_en) begin
            power_ok_out          <= pg_next;
            power_ok_oe           <= ~pg_next; // RQ1 RQ4
            clock_enable_n_out    <= ckn_next;
            clock_enable_n_oe     <= ~ckn_next; // RQ13
            driver_skip_ctl_out   <= driver_skip_ctl_out_next; // RQ7 RQ9
            phase3_pwm_out        <= p3_on & phase3_pwm_in;
            phase3_pwm_oe         <= p3_on; // RQ10
            phase2_boost_sw_on    <= phase2_low_gate; // RQ11
            boot_quarter_slew_out <= quarter_next; // RQ14
        end
    end

endmodule : pgd_top

// *** testbench/pgd_drv_model.sv ***
// model of the external phase driver chip on the mode side
`timescale 1ns/1ns
module pgd_drv_model (
    input  wire logic ref_clk,
    input  wire logic driver_skip_ctl_out,
    input  wire logic phase3_pwm_out,
    input  wire logic phase3_pwm_oe,
    output logic      forced_pwm,
    output logic      zc_enable,
    output logic      phase3_pwm_out_pin
);
    logic last_q = 1'h0;
    assign forced_pwm = driver_skip_ctl_out;
    // high means skip mode, or off after shutdown
    assign zc_enable  = !driver_skip_ctl_out;
    always_ff @(posedge ref_clk)
        if (phase3_pwm_oe) last_q <= phase3_pwm_out;
    // a floating pin must not look like the last driven level
    assign phase3_pwm_out_pin = phase3_pwm_oe ? phase3_pwm_out : ~last_q;
endmodule : pgd_drv_model

// *** testbench/pgd_top_assertions.sv ***
// pin-level checks for the power-good and driver mode logic
`timescale 1ns/1ns
module pgd_chk
    import pgd_pkg::*;
#(
    parameter int PG_DELAY_CYCLES = PG_DELAY_CYC
) (
    input wire logic     ref_clk,
    input wire logic     rst_n,
    input wire logic     bus_wr,
    input wire logic     enable_pin,
    input wire logic     system_rails_good_in,
    input wire logic     phase3_current_sense_pos,
    input wire pgd_reg_s reg_status,
    input wire logic     phase2_low_gate,
    input wire logic     power_ok_out,
    input wire logic     clock_enable_n_out,
    input wire logic     driver_skip_ctl_out,
    input wire logic     phase3_pwm_oe,
    input wire logic     phase2_boost_sw_on,
    input wire logic     boot_quarter_slew_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // cycles of clock-enable low, to time the power-ok delay
    int low_cnt;
    always_ff @(posedge ref_clk)
        if (!rst_n || clock_enable_n_out) low_cnt <= 0;
        else low_cnt <= low_cnt + 1;
    AST_BOOST_GATE: assert property (
        phase2_boost_sw_on |-> $past(phase2_low_gate))
        else $error("boost switch closed with gate low");
    AST_P3_TRISTATE: assert property (
        phase3_pwm_oe |-> !$past(phase3_current_sense_pos, 3)
            && $past(reg_status.all_phases))
        else $error("phase 3 driven while disabled");
    AST_POK_CEN: assert property (
        power_ok_out |-> !clock_enable_n_out)
        else $error("power-ok released with clock-enable high");
    AST_RAILS_LOSS: assert property (
        $fell(system_rails_good_in) |-> ##[1:4] !power_ok_out)
        else $error("power-ok not low after rails loss");
    AST_SKIP_MODE: assert property (
        driver_skip_ctl_out |-> !$past(reg_status.skip_mode))
        else $error("forced PWM asked in skip mode");
    AST_SHUTDOWN_LOW: assert property (
        (!enable_pin) [*5] |-> !power_ok_out)
        else $error("power-ok released while disabled");
    AST_SLEW_POK: assert property (
        power_ok_out && reg_status.slew_active && !bus_wr
            && enable_pin && system_rails_good_in |=> power_ok_out)
        else $error("power-ok pulled low during slew");
    AST_SLEW_CEN: assert property (
        $fell(reg_status.slew_active) && !clock_enable_n_out
            && enable_pin && system_rails_good_in
            |-> (!clock_enable_n_out) [*8])
        else $error("clock-enable released early after slew");
    AST_PG_DELAY: assert property (
        $rose(power_ok_out) && !$past(clock_enable_n_out)
            |-> low_cnt >= PG_DELAY_CYCLES - 1)
        else $error("power-ok released before delay end");
    cover property ($rose(power_ok_out));
    cover property ($fell(driver_skip_ctl_out));
    cover property ($rose(boot_quarter_slew_out));
endmodule : pgd_chk

bind pgd_top pgd_chk #(.PG_DELAY_CYCLES(PG_DELAY_CYCLES)) u_chk (
    .ref_clk                  (ref_clk),
    .rst_n                    (rst_n),
    .bus_wr                   (bus_wr),
    .enable_pin               (enable_pin),
    .system_rails_good_in     (system_rails_good_in),
    .phase3_current_sense_pos (phase3_current_sense_pos),
    .reg_status               (reg_status),
    .phase2_low_gate          (phase2_low_gate),
    .power_ok_out             (power_ok_out),
    .clock_enable_n_out       (clock_enable_n_out),
    .driver_skip_ctl_out      (driver_skip_ctl_out),
    .phase3_pwm_oe            (phase3_pwm_oe),
    .phase2_boost_sw_on       (phase2_boost_sw_on),
    .boot_quarter_slew_out    (boot_quarter_slew_out)
);

// *** testbench/pgd_top_bench.sv ***
// self-checking bench for the power-good and driver mode logic
`timescale 1ns/1ns
module pgd_top_bench;
    import pgd_pkg::*;
    localparam int PGD = 20;
    logic          ref_clk = 1'h0;
    logic          rst_n = 1'h0;
    logic          clk_en = 1'h1;
    logic [AW-1:0] bus_addr = '0;
    logic [DW-1:0] bus_wdata = '0;
    logic          bus_wr = 1'h0;
    logic          bus_rd = 1'h0;
    logic          enable_pin = 1'h0;
    logic          system_rails_good_in = 1'h0;
    logic          phase3_current_sense_pos = 1'h0;
    pgd_fb_s       feedback_sense = '0;
    pgd_reg_s      reg_status = 6'h01;
    logic          phase3_pwm_in = 1'h1;
    logic          phase2_low_gate = 1'h0;
    logic [DW-1:0] bus_rdata;
    logic irq_out, power_ok_out, power_ok_oe, clock_enable_n_out;
    logic clock_enable_n_oe, driver_skip_ctl_out, phase3_pwm_out;
    logic phase3_pwm_oe, phase2_boost_sw_on, boot_quarter_slew_out;
    logic forced_pwm, zc_enable, phase3_pwm_out_pin;
    int err_count = 0;
    int checks_done = 0;
    pgd_top #(.PG_DELAY_CYCLES(PGD)) dut (
        .ref_clk                  (ref_clk),
        .rst_n                    (rst_n),
        .clk_en                   (clk_en),
        .bus_addr                 (bus_addr),
        .bus_wdata                (bus_wdata),
        .bus_wr                   (bus_wr),
        .bus_rd                   (bus_rd),
        .bus_rdata                (bus_rdata),
        .irq_out                  (irq_out),
        .enable_pin               (enable_pin),
        .system_rails_good_in     (system_rails_good_in),
        .phase3_current_sense_pos (phase3_current_sense_pos),
        .feedback_sense           (feedback_sense),
        .reg_status               (reg_status),
        .phase3_pwm_in            (phase3_pwm_in),
        .phase2_low_gate          (phase2_low_gate),
        .power_ok_out             (power_ok_out),
        .power_ok_oe              (power_ok_oe),
        .clock_enable_n_out       (clock_enable_n_out),
        .clock_enable_n_oe        (clock_enable_n_oe),
        .driver_skip_ctl_out      (driver_skip_ctl_out),
        .phase3_pwm_out           (phase3_pwm_out),
        .phase3_pwm_oe            (phase3_pwm_oe),
        .phase2_boost_sw_on       (phase2_boost_sw_on),
        .boot_quarter_slew_out    (boot_quarter_slew_out)
    );
    pgd_drv_model u_drv (
        .ref_clk             (ref_clk),
        .driver_skip_ctl_out (driver_skip_ctl_out),
        .phase3_pwm_out      (phase3_pwm_out),
        .phase3_pwm_oe       (phase3_pwm_oe),
        .forced_pwm          (forced_pwm),
        .zc_enable           (zc_enable),
        .phase3_pwm_out_pin            (phase3_pwm_out_pin)
    );
    always #20 ref_clk = ~ref_clk;
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] e);
        checks_done++;
        if (got !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, e);
        end
    endtask : chk
    task automatic smp(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : smp
    task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'h1;
        @(posedge ref_clk);
        bus_wr <= 1'h0;
    endtask : wreg
    task automatic rreg(input logic [AW-1:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'h1;
        @(posedge ref_clk);
        bus_rd <= 1'h0;
        #1;
        chk(DW'(bus_rdata[7:0] & m), DW'(e));
    endtask : rreg
    task automatic end_sim();
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        end_sim();
    end
    initial begin
        int n;
        smp(4);
        chk(power_ok_out, 1'h0);
        chk(clock_enable_n_out, 1'h1);
        chk(phase3_pwm_oe, 1'h0);
        @(posedge ref_clk) rst_n <= 1'h1;
        rreg(ADDR_CTRL, 8'hFF, 8'h01);
        rreg(ADDR_IRQ_MASK, 8'hFF, 8'h00);
        rreg(4'h2, 8'hFF, 8'h00);
        @(posedge ref_clk) enable_pin <= 1'h1;
        smp(5);
        rreg(ADDR_STATUS, 8'h37, 8'h21);
        @(posedge ref_clk) reg_status.sstart_done <= 1'h1;
        smp(3);
        chk(power_ok_out, 1'h0);
        chk(clock_enable_n_out, 1'h1);
        chk(forced_pwm, 1'h1);
        chk(phase3_pwm_out, 1'h1);
        @(posedge ref_clk) system_rails_good_in <= 1'h1;
        #1;
        for (n = 0; clock_enable_n_out !== 1'h0 && n < 9; n++) smp(1);
        chk(clock_enable_n_out, 1'h0);
        for (n = 0; power_ok_out !== 1'h1 && n < 99; n++) smp(1);
        chk(n, PGD);
        chk(power_ok_oe, 1'h0);
        chk(irq_out, 1'h0);
        rreg(ADDR_IRQ_STAT, 8'h0F, 8'h01);
        wreg(ADDR_IRQ_MASK, 32'h0000_000F);
        @(posedge ref_clk) feedback_sense.below_lower <= 1'h1;
        smp(4);
        chk(power_ok_out, 1'h0);
        chk(power_ok_oe, 1'h1);
        chk(clock_enable_n_oe, 1'h0);
        chk(clock_enable_n_out, 1'h1);
        chk(irq_out, 1'h1);
        rreg(ADDR_IRQ_STAT, 8'h0F, 8'h02);
        smp(1);
        chk(irq_out, 1'h0);
        @(posedge ref_clk) feedback_sense.below_lower <= 1'h0;
        smp(4);
        rreg(ADDR_IRQ_STAT, 8'h0F, 8'h01);
        @(posedge ref_clk) reg_status.slew_active <= 1'h1;
        @(posedge ref_clk) feedback_sense.above_upper <= 1'h1;
        smp(10);
        chk(power_ok_out, 1'h1);
        chk(clock_enable_n_out, 1'h0);
        chk(clock_enable_n_oe, 1'h1);
        @(posedge ref_clk) reg_status.slew_active <= 1'h0;
        smp(300);
        // a second slew must restart the full hold
        @(posedge ref_clk) reg_status.slew_active <= 1'h1;
        @(posedge ref_clk) reg_status.slew_active <= 1'h0;
        smp(490);
        chk(power_ok_out, 1'h1);
        chk(clock_enable_n_out, 1'h0);
        smp(20);
        chk(power_ok_out, 1'h0);
        rreg(ADDR_IRQ_STAT, 8'h0F, 8'h02);
        @(posedge ref_clk) feedback_sense.above_upper <= 1'h0;
        @(posedge ref_clk) reg_status <= 6'h3D;
        smp(2);
        chk(zc_enable, 1'h1);
        @(posedge ref_clk) reg_status <= 6'h1D;
        rreg(ADDR_STATUS, 8'h80, 8'h80);
        smp(510);
        rreg(ADDR_STATUS, 8'h80, 8'h00);
        @(posedge ref_clk) reg_status <= 6'h05;
        @(posedge ref_clk) phase3_current_sense_pos <= 1'h1;
        smp(4);
        chk(phase3_pwm_out_pin, 1'h0);
        chk(phase3_pwm_oe, 1'h0);
        @(posedge ref_clk) phase3_current_sense_pos <= 1'h0;
        @(posedge ref_clk) reg_status.all_phases <= 1'h0;
        smp(2);
        chk(phase3_pwm_oe, 1'h0);
        @(posedge ref_clk) reg_status.all_phases <= 1'h1;
        @(posedge ref_clk) phase2_low_gate <= 1'h1;
        smp(1);
        chk(phase2_boost_sw_on, 1'h1);
        @(posedge ref_clk) phase2_low_gate <= 1'h0;
        smp(1);
        chk(phase2_boost_sw_on, 1'h0);
        wreg(ADDR_CTRL, 32'h0000_0000);
        smp(3);
        chk(power_ok_out, 1'h0);
        chk(driver_skip_ctl_out, 1'h1);
        @(posedge ref_clk) reg_status.sstop_done <= 1'h1;
        smp(2);
        chk(driver_skip_ctl_out, 1'h0);
        chk(phase3_pwm_oe, 1'h0);
        rreg(ADDR_IRQ_STAT, 8'h0F, 8'h0B);
        @(posedge ref_clk) reg_status.sstop_done <= 1'h0;
        wreg(ADDR_CTRL, 32'h0000_0001);
        smp(40);
        @(posedge ref_clk) system_rails_good_in <= 1'h0;
        smp(4);
        chk(power_ok_out, 1'h0);
        chk(clock_enable_n_out, 1'h1);
        chk(boot_quarter_slew_out, 1'h1);
        rreg(ADDR_IRQ_STAT, 8'h0F, 8'h07);
        // frozen block must ignore rails return until enabled
        @(posedge ref_clk) clk_en <= 1'h0;
        system_rails_good_in <= 1'h1;
        smp(6);
        chk(boot_quarter_slew_out, 1'h1);
        chk(clock_enable_n_out, 1'h1);
        @(posedge ref_clk) clk_en <= 1'h1;
        smp(5);
        chk(boot_quarter_slew_out, 1'h0);
        end_sim();
    end
endmodule : pgd_top_bench
